/* File: hdl/pieb_pkg.sv */
// Package of the peripheral interrupt enable bank: register map, field positions and reset values.
// Assumes one core clock and an 8-bit internal register port.
package pieb_pkg;

	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [1:0] OFS_PERIPH_EN = 2'h0;
	localparam logic [1:0] OFS_CAN_EN = 2'h1;
	localparam logic [1:0] OFS_PERIPH_FLAG = 2'h2;
	localparam logic [1:0] OFS_CAN_FLAG = 2'h3;

	// Field positions of peripheral_int_enable_second
	localparam int BIT_COMPARATOR = 6;
	localparam int BIT_BUS_COLLISION = 3;
	localparam int BIT_LOW_VOLTAGE = 2;
	localparam int BIT_TIMER_THREE = 1;

	// Field positions of can_int_enable
	localparam int BIT_INVALID_MSG = 7;
	localparam int BIT_BUS_WAKE = 6;
	localparam int BIT_BUS_ERROR = 5;
	localparam int BIT_TX_BUF_TWO = 4;
	localparam int BIT_TX_BUF_ONE = 3;
	localparam int BIT_TX_BUF_ZERO = 2;
	localparam int BIT_RX_BUF_ONE = 1;
	localparam int BIT_RX_BUF_ZERO = 0;

	// Implemented bits; bits 7, 5, 4 and the capture bit 0 of the first group read zero
	localparam logic [7:0] PERIPH_IMPL_MASK = 8'h4e;
	localparam logic [7:0] CAN_IMPL_MASK = 8'hff;

	// Reset values
	localparam logic [7:0] PERIPH_EN_RESET = 8'h00;
	localparam logic [7:0] CAN_EN_RESET = 8'hff;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Peripheral event pulses, one bit per flag position
	typedef struct packed {
		logic [7:0] periph;
		logic [7:0] can;
	} pieb_evt_t;

	// Register port request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pieb_req_t;

endpackage

/* File: hdl/pieb_top.sv */
// Peripheral interrupt enable bank: two enable registers, two sticky flag registers and the
// combined peripheral interrupt request.
// Assumes event pulses come from logic on sys_clk_in and a master that never needs a wait state.
`timescale 1ns/1ps

module pieb_top
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// Register port
	input wire pieb_pkg::pieb_req_t req_in,
	output logic [7:0] rd_data_out,
	// Peripheral events
	input wire pieb_pkg::pieb_evt_t evt_in,
	// Interrupt requests
	output logic [7:0] periph_pend_out,
	output logic [7:0] can_pend_out,
	output logic irq_out
);

	// Flag update: the hardware set wins over a software write-one clear in the same cycle
	function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
		input logic [7:0] clr, input logic [7:0] impl);
		flag_next = ((cur & ~clr) | set) & impl;
	endfunction

	logic [7:0] periph_en_ff;
	logic [7:0] can_en_ff;
	logic [7:0] periph_flag_ff;
	logic [7:0] can_flag_ff;
	logic [7:0] rd_data_ff;
	logic [7:0] periph_pend_ff;
	logic [7:0] can_pend_ff;
	logic irq_ff;

	logic [7:0] nxt_periph_en;
	logic [7:0] nxt_can_en;
	logic [7:0] nxt_periph_flag;
	logic [7:0] nxt_can_flag;
	logic [7:0] nxt_rd_data;
	logic [7:0] nxt_periph_pend;
	logic [7:0] nxt_can_pend;
	logic nxt_irq;

	// Address decode
	wire logic wr_periph_en = req_in.wr && (req_in.addr == pieb_pkg::OFS_PERIPH_EN);
	wire logic wr_can_en = req_in.wr && (req_in.addr == pieb_pkg::OFS_CAN_EN);
	wire logic wr_periph_flag = req_in.wr && (req_in.addr == pieb_pkg::OFS_PERIPH_FLAG);
	wire logic wr_can_flag = req_in.wr && (req_in.addr == pieb_pkg::OFS_CAN_FLAG);
	wire logic [7:0] periph_clr = wr_periph_flag ? req_in.wdata : 8'h00;
	wire logic [7:0] can_clr = wr_can_flag ? req_in.wdata : 8'h00;

	// Enable registers; unimplemented bits never store a one
	assign nxt_periph_en = wr_periph_en ? (req_in.wdata & pieb_pkg::PERIPH_IMPL_MASK) : periph_en_ff;
	assign nxt_can_en = wr_can_en ? (req_in.wdata & pieb_pkg::CAN_IMPL_MASK) : can_en_ff;

	// Sticky flags; only a software write of one clears them
	assign nxt_periph_flag = flag_next(periph_flag_ff, evt_in.periph, periph_clr, pieb_pkg::PERIPH_IMPL_MASK);
	assign nxt_can_flag = flag_next(can_flag_ff, evt_in.can, can_clr, pieb_pkg::CAN_IMPL_MASK);

	// Read mux; stands only in the cycle after the read strobe
	wire logic [7:0] rd_mux =
		(req_in.addr == pieb_pkg::OFS_PERIPH_EN) ? periph_en_ff :
		(req_in.addr == pieb_pkg::OFS_CAN_EN) ? can_en_ff :
		(req_in.addr == pieb_pkg::OFS_PERIPH_FLAG) ? periph_flag_ff :
		can_flag_ff;
	assign nxt_rd_data = req_in.rd ? rd_mux : pieb_pkg::READ_IDLE;

	// Per-source gating, each enable bit passes or blocks its own flag
	assign nxt_periph_pend = periph_flag_ff & periph_en_ff;
	// CAN sources gated the same way
	assign nxt_can_pend = can_flag_ff & can_en_ff;
	// Any enabled flag raises the request
	assign nxt_irq = |{nxt_periph_pend, nxt_can_pend};

	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			periph_en_ff <= pieb_pkg::PERIPH_EN_RESET;
			can_en_ff <= pieb_pkg::CAN_EN_RESET;
			periph_flag_ff <= pieb_pkg::FLAG_RESET;
			can_flag_ff <= pieb_pkg::FLAG_RESET;
		end
		else
		begin
			periph_en_ff <= nxt_periph_en;
			can_en_ff <= nxt_can_en;
			periph_flag_ff <= nxt_periph_flag;
			can_flag_ff <= nxt_can_flag;
		end
	end

	// Outputs are registered, so the request lags the flag by one cycle
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rd_data_ff <= pieb_pkg::READ_IDLE;
			periph_pend_ff <= 8'h00;
			can_pend_ff <= 8'h00;
			irq_ff <= 1'b0;
		end
		else
		begin
			rd_data_ff <= nxt_rd_data;
			periph_pend_ff <= nxt_periph_pend;
			can_pend_ff <= nxt_can_pend;
			irq_ff <= nxt_irq;
		end
	end

	assign rd_data_out = rd_data_ff;
	assign periph_pend_out = periph_pend_ff;
	assign can_pend_out = can_pend_ff;
	assign irq_out = irq_ff;

	a_unimpl_read_zero: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(req_in.rd && (req_in.addr == pieb_pkg::OFS_PERIPH_EN))
		|=> (rd_data_out[7] == 1'b0) && (rd_data_out[5:4] == 2'b00))
		else $error("Unimplemented enable bits read as one");

	a_comparator_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		##1 periph_pend_out[pieb_pkg::BIT_COMPARATOR] ==
		($past(periph_flag_ff[pieb_pkg::BIT_COMPARATOR]) && $past(periph_en_ff[pieb_pkg::BIT_COMPARATOR])))
		else $error("Comparator request not gated by its enable");

	a_collision_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(periph_flag_ff[pieb_pkg::BIT_BUS_COLLISION] && !periph_en_ff[pieb_pkg::BIT_BUS_COLLISION])
		|=> !periph_pend_out[pieb_pkg::BIT_BUS_COLLISION])
		else $error("Bus collision request passed while disabled");

	a_low_volt_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(periph_flag_ff[pieb_pkg::BIT_LOW_VOLTAGE] && periph_en_ff[pieb_pkg::BIT_LOW_VOLTAGE])
		|=> periph_pend_out[pieb_pkg::BIT_LOW_VOLTAGE] && irq_out)
		else $error("Low voltage request blocked while enabled");

	a_timer_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(wr_periph_en && !req_in.wdata[pieb_pkg::BIT_TIMER_THREE])
		|=> ##1 !periph_pend_out[pieb_pkg::BIT_TIMER_THREE])
		else $error("Timer overflow request passed after disable write");

	a_invalid_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		##1 can_pend_out[pieb_pkg::BIT_INVALID_MSG] ==
		($past(can_flag_ff[pieb_pkg::BIT_INVALID_MSG]) && $past(can_en_ff[pieb_pkg::BIT_INVALID_MSG])))
		else $error("Invalid message request not gated by its enable");

	a_wake_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(evt_in.can[pieb_pkg::BIT_BUS_WAKE] && can_en_ff[pieb_pkg::BIT_BUS_WAKE] && !wr_can_en)
		|=> ##1 can_pend_out[pieb_pkg::BIT_BUS_WAKE])
		else $error("Wake event not raised two cycles later");

	a_error_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		!can_en_ff[pieb_pkg::BIT_BUS_ERROR] |=> !can_pend_out[pieb_pkg::BIT_BUS_ERROR])
		else $error("Bus error request passed while disabled");

	a_tx_buf_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		##1 can_pend_out[4:2] == ($past(can_flag_ff[4:2]) & $past(can_en_ff[4:2])))
		else $error("Transmit buffer requests not gated per bit");

	a_rx_buf_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		##1 can_pend_out[1:0] == ($past(can_flag_ff[1:0]) & $past(can_en_ff[1:0])))
		else $error("Receive buffer requests not gated per bit");

	a_flag_sticky: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(can_flag_ff[pieb_pkg::BIT_TX_BUF_ZERO] && !wr_can_flag)
		|=> can_flag_ff[pieb_pkg::BIT_TX_BUF_ZERO])
		else $error("Flag dropped without a software clear");

	a_irq_combined: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		##1 irq_out == ($past(|(periph_flag_ff & periph_en_ff)) || $past(|(can_flag_ff & can_en_ff))))
		else $error("Interrupt output disagrees with enabled flags");

	a_set_beats_clear: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(evt_in.periph[pieb_pkg::BIT_COMPARATOR] && wr_periph_flag)
		|=> periph_flag_ff[pieb_pkg::BIT_COMPARATOR])
		else $error("Event lost under a simultaneous clear");

	a_read_one_cycle: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		!req_in.rd |=> rd_data_out == 8'h00)
		else $error("Read data stands outside its cycle");

	a_unimpl_never_stored: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wr_periph_en
		|=> (periph_en_ff[7] == 1'b0) && (periph_en_ff[5:4] == 2'h0))
		else $error("Unimplemented enable bit stored a one");

	a_read_periph_en: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(req_in.rd && (req_in.addr == pieb_pkg::OFS_PERIPH_EN))
		|=> (rd_data_out == $past(periph_en_ff)) && (rd_data_out[0] == 1'b0))
		else $error("First enable register read back wrong");

	a_en_write_lands: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wr_periph_en
		|=> periph_en_ff == ($past(req_in.wdata) & pieb_pkg::PERIPH_IMPL_MASK))
		else $error("First enable register write did not land");

	a_comparator_block: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(periph_flag_ff[pieb_pkg::BIT_COMPARATOR] && !periph_en_ff[pieb_pkg::BIT_COMPARATOR])
		|=> !periph_pend_out[pieb_pkg::BIT_COMPARATOR])
		else $error("Comparator request passed while disabled");

	a_collision_pass: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(periph_flag_ff[pieb_pkg::BIT_BUS_COLLISION] && periph_en_ff[pieb_pkg::BIT_BUS_COLLISION])
		|=> periph_pend_out[pieb_pkg::BIT_BUS_COLLISION] && irq_out)
		else $error("Bus collision request blocked while enabled");

	a_low_volt_block: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(periph_flag_ff[pieb_pkg::BIT_LOW_VOLTAGE] && !periph_en_ff[pieb_pkg::BIT_LOW_VOLTAGE])
		|=> !periph_pend_out[pieb_pkg::BIT_LOW_VOLTAGE])
		else $error("Low voltage request passed while disabled");

	a_timer_pass: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(periph_flag_ff[pieb_pkg::BIT_TIMER_THREE] && periph_en_ff[pieb_pkg::BIT_TIMER_THREE])
		|=> periph_pend_out[pieb_pkg::BIT_TIMER_THREE] && irq_out)
		else $error("Timer overflow request blocked while enabled");

	a_invalid_block: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(can_flag_ff[pieb_pkg::BIT_INVALID_MSG] && !can_en_ff[pieb_pkg::BIT_INVALID_MSG])
		|=> !can_pend_out[pieb_pkg::BIT_INVALID_MSG])
		else $error("Invalid message request passed while disabled");

	a_read_can_en: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(req_in.rd && (req_in.addr == pieb_pkg::OFS_CAN_EN))
		|=> rd_data_out == $past(can_en_ff))
		else $error("Second enable register read back wrong");

	a_wake_block: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(can_flag_ff[pieb_pkg::BIT_BUS_WAKE] && !can_en_ff[pieb_pkg::BIT_BUS_WAKE])
		|=> !can_pend_out[pieb_pkg::BIT_BUS_WAKE])
		else $error("Wake request passed while disabled");

	a_error_pass: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(can_flag_ff[pieb_pkg::BIT_BUS_ERROR] && can_en_ff[pieb_pkg::BIT_BUS_ERROR])
		|=> can_pend_out[pieb_pkg::BIT_BUS_ERROR] && irq_out)
		else $error("Bus error request blocked while enabled");

	a_tx_disable_write: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(wr_can_en && (req_in.wdata[pieb_pkg::BIT_TX_BUF_TWO:pieb_pkg::BIT_TX_BUF_ZERO] == 3'h0))
		|=> ##1 (can_pend_out[pieb_pkg::BIT_TX_BUF_TWO:pieb_pkg::BIT_TX_BUF_ZERO] == 3'h0))
		else $error("Transmit buffer request passed after disable write");

	a_tx_en_lands: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wr_can_en
		|=> can_en_ff[4:2] == $past(req_in.wdata[4:2]))
		else $error("Transmit buffer enables did not land");

	a_rx_en_lands: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wr_can_en
		|=> can_en_ff[1:0] == $past(req_in.wdata[1:0]))
		else $error("Receive buffer enables did not land");

	a_flag_clear_works: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		(wr_can_flag && req_in.wdata[pieb_pkg::BIT_TX_BUF_ZERO] && !evt_in.can[pieb_pkg::BIT_TX_BUF_ZERO])
		|=> !can_flag_ff[pieb_pkg::BIT_TX_BUF_ZERO])
		else $error("Flag not cleared by a written one");

	a_event_sets_flag: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		evt_in.periph[pieb_pkg::BIT_BUS_COLLISION]
		|=> periph_flag_ff[pieb_pkg::BIT_BUS_COLLISION])
		else $error("Event did not set its flag");

	a_irq_from_pend: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		irq_out == ((|periph_pend_out) || (|can_pend_out)))
		else $error("Interrupt output disagrees with pending outputs");

endmodule

/* File: sim/peripheral_irq_enable_bank_test.sv */
// Self-checking bench of the peripheral interrupt enable bank: a cycle model, directed and random traffic.
// Assumes the register port and event pulses of pieb_top, one 50 MHz clock and an active-low async reset.
`timescale 1ns/1ps
module peripheral_irq_enable_bank_test;
	logic sys_clk_in;
	logic reset_n_in;
	pieb_pkg::pieb_req_t req;
	pieb_pkg::pieb_evt_t evt;
	logic [7:0] rd_data;
	logic [7:0] p_pend;
	logic [7:0] c_pend;
	logic irq;
	logic [7:0] m_en1, m_en2, m_f1, m_f2, m_rd, m_pp, m_cp;
	logic m_irq;
	int err_total;
	int checks;
	int seed;

	pieb_top i_dut
	(
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.req_in(req),
		.rd_data_out(rd_data),
		.evt_in(evt),
		.periph_pend_out(p_pend),
		.can_pend_out(c_pend),
		.irq_out(irq)
	);

	initial
	begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end

	// Model mirrors the documented register behaviour; flags are sticky until a one is written
	wire wr1 = req.wr && req.addr == pieb_pkg::OFS_PERIPH_FLAG;
	wire wr2 = req.wr && req.addr == pieb_pkg::OFS_CAN_FLAG;
	always @(posedge sys_clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			m_en1 <= 8'h00;
			m_en2 <= 8'hff;
			m_f1 <= 8'h00;
			m_f2 <= 8'h00;
			m_rd <= 8'h00;
			m_pp <= 8'h00;
			m_cp <= 8'h00;
			m_irq <= 1'b0;
		end
		else
		begin
			m_rd <= !req.rd ? 8'h00 : req.addr == 2'h0 ? m_en1 : req.addr == 2'h1 ? m_en2 : req.addr == 2'h2 ? m_f1 : m_f2;
			m_pp <= m_f1 & m_en1;
			m_cp <= m_f2 & m_en2;
			m_irq <= |{m_f1 & m_en1, m_f2 & m_en2};
			if (req.wr && req.addr == pieb_pkg::OFS_PERIPH_EN)
				m_en1 <= req.wdata & pieb_pkg::PERIPH_IMPL_MASK;
			if (req.wr && req.addr == pieb_pkg::OFS_CAN_EN)
				m_en2 <= req.wdata;
			m_f1 <= ((m_f1 & ~(wr1 ? req.wdata : 8'h00)) | evt.periph) & pieb_pkg::PERIPH_IMPL_MASK;
			m_f2 <= (m_f2 & ~(wr2 ? req.wdata : 8'h00)) | evt.can;
		end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Outputs are settled by the falling edge
	always @(negedge sys_clk_in)
	begin
		check("rd_data_out", m_rd, rd_data);
		check("periph_pend_out", m_pp, p_pend);
		check("can_pend_out", m_cp, c_pend);
		check("irq_out", {7'h00, m_irq}, {7'h00, irq});
	end

	task automatic op(input logic [1:0] a, input logic [7:0] d, input logic w, input logic r, input logic [15:0] e);
		@(posedge sys_clk_in);
		req <= '{addr: a, wdata: d, wr: w, rd: r};
		evt <= e;
	endtask

	task automatic complete_run();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		int k;
		req = '0;
		evt = '0;
		reset_n_in = 1'b0;
		err_total = 0;
		checks = 0;
		seed = $urandom(40203);
		repeat (8) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		// Reset values, then unimplemented bits dropped, read back to back
		for (k = 0; k < 4; k++)
			op(k[1:0], 8'h00, 1'b0, 1'b1, 16'h0000);
		op(2'h0, 8'hff, 1'b1, 1'b0, 16'hffff);
		op(2'h0, 8'h00, 1'b0, 1'b1, 16'h0000);
		op(2'h2, 8'h00, 1'b0, 1'b1, 16'h0000);
		// Each source alone, enabled then disabled
		for (k = 0; k < 16; k++)
		begin
			op(2'h0, 8'h4e, 1'b1, 1'b0, 16'h0001 << k);
			repeat (3) op(2'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
			op(k < 8 ? 2'h1 : 2'h0, 8'h00, 1'b1, 1'b0, 16'h0000);
			repeat (3) op(2'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
			op(2'h2, 8'hff, 1'b1, 1'b0, 16'h0000);
			op(2'h3, 8'hff, 1'b1, 1'b0, 16'h0000);
			op(2'h1, 8'hff, 1'b1, 1'b0, 16'h0000);
		end
		// Random traffic, with a reset in mid-run; set meets clear now and then
		for (k = 0; k < 4000; k++)
		begin
			if (k == 2000)
			begin
				// Idle the port first, so no strobe stays standing through reset and is taken after it
				op(2'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
				reset_n_in <= 1'b0;
				repeat (3) @(posedge sys_clk_in);
				reset_n_in <= 1'b1;
			end
			case ($urandom_range(2))
				0: op(2'($urandom), 8'($urandom), 1'b1, 1'b0, 16'($urandom) & 16'($urandom));
				1: op(2'($urandom), 8'h00, 1'b0, 1'b1, 16'($urandom) & 16'($urandom));
				default: op(2'h0, 8'h00, 1'b0, 1'b0, 16'($urandom) & 16'($urandom) & 16'($urandom));
			endcase
		end
		op(2'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
		repeat (4) @(posedge sys_clk_in);
		complete_run();
	end
endmodule
